// >>> verilog/pllr_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pllr_defines.svh"

module pllr_ctl
   import pllr_pkg::*;
(
   input  wire logic        CLK_SYS_IN,
   input  wire logic        SYS_RST_IN,
   input  wire logic [5:0]  AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   output logic      [31:0] AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   output logic             IRQ_OUT,
   pllr_if.ctl              link
);
   localparam int HALF = `PLLR_SCAN_HALF;
   localparam int RSTC = `PLLR_RST_CYC;
   localparam int LEN  = `PLLR_CHAIN_LEN;

   logic [31:0]     set_q [`PLLR_SET_WORDS];
   logic [LEN-1:0]  chain;
   logic            ack_q, rst_aft_q, irq_st_q, irq_msk_q, go;
   logic            wr, rd, done_evt;
   logic [1:0]      done_q;
   logic [5:0]      set_off;
   logic [3:0]      div_q;
   logic            sclk_q, fall, en_q, dat_q, cmt_q, prst_q;
   logic [7:0]      bit_q, cnt_q;
   pllr_ctl_state_e st_q;

   assign chain = {set_q[4][15:0], set_q[3], set_q[2], set_q[1], set_q[0]};
   assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
   assign wr = AVS_WRITE_IN & ack_q;
   assign rd = AVS_READ_IN & ~ack_q;
   assign go = wr && AVS_ADDRESS_IN == `PLLR_REG_CTRL
               && AVS_WRITEDATA_IN[`PLLR_CTRL_START] && st_q == PLLR_IDLE;
   assign IRQ_OUT = irq_st_q & irq_msk_q;
   // Byte offset into the settings window, counted from its base
   assign set_off = AVS_ADDRESS_IN - `PLLR_REG_SET0;

   // One wait state per access
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         ack_q <= 1'b0;
      else
         ack_q <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         AVS_READDATA_OUT <= 32'h0;
      else if (rd)
      begin
         if (AVS_ADDRESS_IN == `PLLR_REG_CTRL)
            AVS_READDATA_OUT <= {30'h0, rst_aft_q, 1'b0};
         else if (AVS_ADDRESS_IN == `PLLR_REG_STATUS)
            AVS_READDATA_OUT <= {30'h0, done_q[1], st_q != PLLR_IDLE};
         else if (AVS_ADDRESS_IN == `PLLR_REG_IRQ_ST)
            AVS_READDATA_OUT <= {31'h0, irq_st_q};
         else if (AVS_ADDRESS_IN == `PLLR_REG_IRQ_MSK)
            AVS_READDATA_OUT <= {31'h0, irq_msk_q};
         else if (AVS_ADDRESS_IN >= `PLLR_REG_SET0
                  && AVS_ADDRESS_IN <= `PLLR_REG_SET0 + 6'h10)
            AVS_READDATA_OUT <= set_q[set_off[4:2]];
         else
            AVS_READDATA_OUT <= 32'h0;
      end

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
      begin
         rst_aft_q <= 1'b0;
         irq_msk_q <= 1'b0;
         for (int i = 0; i < `PLLR_SET_WORDS; i++)
            set_q[i] <= 32'h0;
      end
      else if (wr)
      begin
         if (AVS_ADDRESS_IN == `PLLR_REG_CTRL)
            rst_aft_q <= AVS_WRITEDATA_IN[`PLLR_CTRL_RSTAFT];
         else if (AVS_ADDRESS_IN == `PLLR_REG_IRQ_MSK)
            irq_msk_q <= AVS_WRITEDATA_IN[0];
         else if (AVS_ADDRESS_IN >= `PLLR_REG_SET0
                  && AVS_ADDRESS_IN <= `PLLR_REG_SET0 + 6'h10
                  && AVS_ADDRESS_IN[1:0] == 2'b00
                  && st_q == PLLR_IDLE)
            set_q[set_off[4:2]] <= AVS_WRITEDATA_IN;
      end

   // Completion flag, set wins over write-one-to-clear
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         irq_st_q <= 1'b0;
      else if (done_evt)
         irq_st_q <= 1'b1;
      else if (wr && AVS_ADDRESS_IN == `PLLR_REG_IRQ_ST
               && AVS_WRITEDATA_IN[0])
         irq_st_q <= 1'b0;

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         done_q <= 2'b00;
      else
         done_q <= {done_q[0], link.done};

   // Shift clock divider
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
      begin
         div_q  <= 4'h0;
         sclk_q <= 1'b0;
      end
      else if (div_q == 4'(HALF - 1))
      begin
         div_q  <= 4'h0;
         sclk_q <= ~sclk_q;
      end
      else
         div_q <= div_q + 4'h1;

   assign fall = div_q == 4'(HALF - 1) && sclk_q;
   assign done_evt = (st_q == PLLR_WAIT_LO && !done_q[1] && !rst_aft_q)
                     || (st_q == PLLR_RESET && cnt_q == 8'(RSTC - 1));

   // commit for one shift clock cycle
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         cmt_q <= 1'b0;
      else if (fall)
         cmt_q <= st_q == PLLR_COMMIT;

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
      begin
         st_q   <= PLLR_IDLE;
         en_q   <= 1'b0;
         dat_q  <= 1'b0;
         prst_q <= 1'b0;
         bit_q  <= 8'h0;
         cnt_q  <= 8'h0;
      end
      else
         case (st_q)
            PLLR_IDLE:
               if (go)
               begin
                  cnt_q <= 8'h0;
                  if (done_q[1])
                  begin
                     prst_q <= 1'b1;
                     st_q   <= PLLR_CLEAR;
                  end
                  else
                     st_q <= PLLR_ARM;
               end
            PLLR_CLEAR:
               if (prst_q)
               begin
                  cnt_q <= cnt_q + 8'h1;
                  if (cnt_q == 8'(RSTC - 1))
                     prst_q <= 1'b0;
               end
               else if (!done_q[1])
                  st_q <= PLLR_ARM;
            // enable one cycle ahead of data
            PLLR_ARM:
               if (fall)
               begin
                  en_q  <= 1'b1;
                  bit_q <= 8'h0;
                  st_q  <= PLLR_SHIFT;
               end
            PLLR_SHIFT:
               if (fall)
               begin
                  if (bit_q == 8'(LEN))
                  begin
                     en_q <= 1'b0;
                     st_q <= PLLR_COMMIT;
                  end
                  else
                  begin
                     dat_q <= chain[bit_q];
                     bit_q <= bit_q + 8'h1;
                  end
               end
            PLLR_COMMIT:
               if (fall)
                  st_q <= PLLR_WAIT_HI;
            PLLR_WAIT_HI:
               if (done_q[1])
                  st_q <= PLLR_WAIT_LO;
            PLLR_WAIT_LO:
               if (!done_q[1])
               begin
                  cnt_q <= 8'h0;
                  if (rst_aft_q)
                  begin
                     prst_q <= 1'b1;
                     st_q   <= PLLR_RESET;
                  end
                  // idle again, ready for the next load
                  else
                     st_q <= PLLR_IDLE;
               end
            PLLR_RESET:
            begin
               cnt_q <= cnt_q + 8'h1;
               if (cnt_q == 8'(RSTC - 1))
               begin
                  prst_q <= 1'b0;
                  st_q   <= PLLR_IDLE;
               end
            end
            default:
               st_q <= PLLR_IDLE;
         endcase

   assign link.scan_clk  = sclk_q;
   assign link.scan_en   = en_q;
   assign link.scan_data = dat_q;
   assign link.commit    = cmt_q;
   assign link.pll_rst   = prst_q;
endmodule

`default_nettype wire

// >>> verilog/pllr_defines.svh
`ifndef PLLR_DEFINES_SVH
`define PLLR_DEFINES_SVH

// Scan chain layout, first bit shifted lands at index 0
`define PLLR_CHAIN_LEN   144
`define PLLR_CNT_BITS    18
`define PLLR_POST_NUM    5
`define PLLR_POST_BASE(i) ((4 - (i)) * 18)
`define PLLR_FB_BASE     90
`define PLLR_PRE_BASE    108
`define PLLR_CP_POS      126
`define PLLR_LF_POS      135
`define PLLR_LOOP_W      9

// Timing
`define PLLR_CLK_NS      5
`define PLLR_RST_NS      10
`define PLLR_RST_CYC     ((`PLLR_RST_NS + `PLLR_CLK_NS - 1) / `PLLR_CLK_NS)
`define PLLR_UPDATE_CYC  16
`define PLLR_SCAN_HALF   4

// Controller register map, byte addresses
`define PLLR_REG_CTRL    6'h00
`define PLLR_REG_STATUS  6'h04
`define PLLR_REG_IRQ_ST  6'h08
`define PLLR_REG_IRQ_MSK 6'h0c
`define PLLR_REG_SET0    6'h10
`define PLLR_SET_WORDS   5
`define PLLR_CTRL_START  0
`define PLLR_CTRL_RSTAFT 1

`endif

// >>> verilog/pllr_pkg.sv
`default_nettype none

package pllr_pkg;

   typedef struct packed {
      logic       odd;
      logic       bypass;
      logic [7:0] high;
      logic [7:0] low;
   } pllr_counter_s;

   typedef enum logic [3:0] {
      PLLR_IDLE    = 4'b0000,
      PLLR_CLEAR   = 4'b0001,
      PLLR_ARM     = 4'b0010,
      PLLR_SHIFT   = 4'b0011,
      PLLR_COMMIT  = 4'b0100,
      PLLR_WAIT_HI = 4'b0101,
      PLLR_WAIT_LO = 4'b0110,
      PLLR_RESET   = 4'b0111
   } pllr_ctl_state_e;

endpackage

`default_nettype wire

// >>> verilog/pllr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pllr_if;
   logic scan_clk;
   logic scan_en;
   logic scan_data;
   logic commit;
   logic pll_rst;
   logic done;

   modport dev
   (
      input  scan_clk,
      input  scan_en,
      input  scan_data,
      input  commit,
      input  pll_rst,
      output done
   );

   modport ctl
   (
      output scan_clk,
      output scan_en,
      output scan_data,
      output commit,
      output pll_rst,
      input  done
   );
endinterface

`default_nettype wire

// >>> verilog/pllr_device.sv
// Overview of operation
// - Controller raises enable before first data bit
// - Capture starts second shift edge after enable
// - Controller shifts 144 bits, then drops enable
// - One-shift-clock-cycle commit strobe loads active settings
// - Done high during update, falls when loaded
// - Controller resets PLL after the update if rst_aft_q set
// - Sequence repeats without limit
// - No phase field, PLL reset restarts outputs unshifted
// - Post-scale divide equals high plus low
// - Bypass bit set divides by one
// - Even mode falls on rising VCO edge
// - Odd mode falls on falling VCO edge
// - Seven counters take 18 bits each
// - First bit is fifth counter low LSB
// - Last bit is loop filter MSB
// - Controller clears done by PLL reset
// - Bypass set ignores other counter bits
`timescale 1ns/1ps
`default_nettype none
`include "pllr_defines.svh"

module pllr_device
   import pllr_pkg::*;
#(
   parameter int UPDATE_CYC = `PLLR_UPDATE_CYC
)
(
   input  wire logic       CLK_SYS_IN,
   input  wire logic       SYS_RST_IN,
   output logic [4:0]      PLL_CLK_OUT,
   output logic [8:0]      FB_FACTOR_OUT,
   output logic [8:0]      PRE_FACTOR_OUT,
   output logic [8:0]      CHARGE_PUMP_CODE_OUT,
   output logic [8:0]      LOOP_FILTER_OUT,
   pllr_if.dev             link
);
   localparam int LEN = `PLLR_CHAIN_LEN;
   localparam int CB  = `PLLR_CNT_BITS;
   localparam int LW  = `PLLR_LOOP_W;

   logic [2:0]     sclk_q;
   logic [1:0]     en_q;
   logic [1:0]     dat_q;
   logic [1:0]     cmt_q;
   logic [1:0]     prst_q;
   logic           rise;
   logic           pll_rst;
   logic           armed_q;
   logic [LEN-1:0] chain_q;
   logic [LEN-1:0] active_q;
   logic [LEN-1:0] pend_q;
   logic           done_q;
   logic [7:0]     upd_q;

   // Effective divide factor of one counter field
   function automatic logic [8:0] div_factor(input pllr_counter_s c);
      logic [8:0] f;
      f = 9'd0;
      if (c.bypass)
         f = 9'd1;
      else
         f = {1'b0, c.high} + {1'b0, c.low};
      if (f == 9'd0)
         f = 9'd1;
      return f;
   endfunction

   // Link inputs cross into the system clock
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
      begin
         sclk_q <= 3'b000;
         en_q   <= 2'b00;
         dat_q  <= 2'b00;
         cmt_q  <= 2'b00;
         prst_q <= 2'b00;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], link.scan_clk};
         en_q   <= {en_q[0], link.scan_en};
         dat_q  <= {dat_q[0], link.scan_data};
         cmt_q  <= {cmt_q[0], link.commit};
         prst_q <= {prst_q[0], link.pll_rst};
      end

   assign rise    = sclk_q[1] & ~sclk_q[2];
   assign pll_rst = prst_q[1];

   // first enabled edge arms, later edges capture
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         armed_q <= 1'b0;
      else if (rise)
         armed_q <= en_q[1];

   // shift only while enabled and armed
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         chain_q <= '0;
      else if (rise && en_q[1] && armed_q)
         // first bit ends at index zero
         chain_q <= {dat_q[1], chain_q[LEN-1:1]};

   // commit starts an update, done marks it
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
      begin
         done_q <= 1'b0;
         upd_q  <= 8'h0;
         pend_q <= '0;
      end
      else if (pll_rst)
      begin
         done_q <= 1'b0;
         upd_q  <= 8'h0;
      end
      else if (rise && cmt_q[1] && !done_q)
      begin
         done_q <= 1'b1;
         upd_q  <= 8'h0;
         pend_q <= chain_q;
      end
      else if (done_q)
      begin
         upd_q <= upd_q + 8'h1;
         if (upd_q == 8'(UPDATE_CYC - 1))
            done_q <= 1'b0;
      end

   // active settings change only as the update ends
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
         active_q <= '0;
      else if (done_q && !pll_rst && upd_q == 8'(UPDATE_CYC - 1))
         active_q <= pend_q;

   assign link.done = done_q;

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
      if (SYS_RST_IN)
      begin
         FB_FACTOR_OUT        <= 9'h0;
         PRE_FACTOR_OUT       <= 9'h0;
         CHARGE_PUMP_CODE_OUT <= 9'h0;
         LOOP_FILTER_OUT      <= 9'h0;
      end
      else
      begin
         FB_FACTOR_OUT  <= div_factor(active_q[`PLLR_FB_BASE +: CB]);
         PRE_FACTOR_OUT <= div_factor(active_q[`PLLR_PRE_BASE +: CB]);
         CHARGE_PUMP_CODE_OUT <= active_q[`PLLR_CP_POS +: LW];
         LOOP_FILTER_OUT      <= active_q[`PLLR_LF_POS +: LW];
      end

   // Post-scale counters; one system cycle is half a VCO period
   genvar gi;
   generate
      for (gi = 0; gi < `PLLR_POST_NUM; gi++)
      begin : g_post
         pllr_counter_s cfg;
         logic [8:0]    len_hi;
         logic [8:0]    len_lo;
         logic [8:0]    cur_len;
         logic [8:0]    hc_q;
         logic          ph_q;

         assign cfg = active_q[`PLLR_POST_BASE(gi) +: CB];

         always_comb
         begin
            len_hi = 9'd1;
            len_lo = 9'd1;
            if (!cfg.bypass)
            begin
               // odd mode moves the fall half a cycle
               len_hi = {cfg.high, 1'b0} - {8'h0, cfg.odd};
               len_lo = {cfg.low, 1'b0} + {8'h0, cfg.odd};
            end
            if (len_hi == 9'd0)
               len_hi = 9'd1;
            if (len_lo == 9'd0)
               len_lo = 9'd1;
            cur_len = ph_q ? len_hi : len_lo;
         end

         always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
            if (SYS_RST_IN)
            begin
               hc_q <= 9'h0;
               ph_q <= 1'b1;
            end
            // no phase field, reset restarts unshifted
            else if (pll_rst)
            begin
               hc_q <= 9'h0;
               ph_q <= 1'b1;
            end
            else if (hc_q + 9'd1 >= cur_len)
            begin
               hc_q <= 9'h0;
               ph_q <= ~ph_q;
            end
            else
               hc_q <= hc_q + 9'd1;

         assign PLL_CLK_OUT[gi] = ph_q;
      end
   endgenerate
endmodule

`default_nettype wire

// >>> tb/pllr_link_sva.sv
`timescale 1ns/1ps
`default_nettype none

module pllr_link_sva
#(
   parameter int UPDATE_CYC = 16
)
(
   input wire logic CLK_SYS_IN,
   input wire logic SYS_RST_IN,
   input wire logic scan_clk,
   input wire logic scan_en,
   input wire logic scan_data,
   input wire logic commit,
   input wire logic pll_rst,
   input wire logic done
);
   logic       clk_prev_q;
   logic [7:0] shift_cnt_q;
   logic [7:0] busy_cnt_q;

   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         clk_prev_q <= 1'b0;
      else
         clk_prev_q <= scan_clk;
   end

   // Shift clock rises seen while the enable is up
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         shift_cnt_q <= 8'h00;
      else if (!scan_en)
         shift_cnt_q <= 8'h00;
      else
         shift_cnt_q <= shift_cnt_q + {7'h00, scan_clk & ~clk_prev_q};
   end

   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         busy_cnt_q <= 8'h00;
      else if (!done)
         busy_cnt_q <= 8'h00;
      else
         busy_cnt_q <= busy_cnt_q + 8'h01;
   end

   sequence s_commit_pulse;
      commit [*8] ##1 !commit;
   endsequence

   sequence s_busy;
      done [*8] ##[1:40] !done;
   endsequence

   a_commit_one_period: assert property ($rose(commit) |-> s_commit_pulse)
      else $error("commit strobe not one shift period");
   a_commit_en_low: assert property (commit |-> !scan_en)
      else $error("commit while shift enable high");
   a_shift_count: assert property ($fell(scan_en) |-> shift_cnt_q == 8'h91)
      else $error("shift rise count wrong");
   a_change_at_low: assert property
      ($changed(scan_data) || $changed(scan_en) |-> !scan_clk)
      else $error("scan line changed with shift clock high");
   a_done_after_commit: assert property ($rose(commit) |-> ##[1:16] done)
      else $error("done did not follow commit");
   a_done_span: assert property ($rose(done) |-> s_busy)
      else $error("done high time out of range");
   a_done_width: assert property ($fell(done) |-> busy_cnt_q == UPDATE_CYC)
      else $error("done high time not update length");
   a_rst_width: assert property
      ($rose(pll_rst) |-> pll_rst [*2] ##1 !pll_rst)
      else $error("PLL reset pulse width wrong");
   a_rst_clears_done: assert property (pll_rst |-> ##[1:6] !done)
      else $error("PLL reset did not clear done");
   a_load_idle: assert property ($rose(scan_en) |-> !done && !commit)
      else $error("load started while busy");
endmodule

`default_nettype wire

// >>> tb/pll_scan_chain_reconfig_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pllr_defines.svh"

module pll_scan_chain_reconfig_tb_top
   import pllr_pkg::*;
;
   localparam int UPD = `PLLR_UPDATE_CYC;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic [5:0]          addr = 6'h00;
   logic                rd = 1'b0;
   logic                wr = 1'b0;
   logic [31:0]         wdata = 32'h0;
   logic [31:0]         rdata;
   logic                waitreq;
   logic                irq;
   logic [4:0]          pll_clk;
   logic [8:0]          fb;
   logic [8:0]          pre;
   logic [8:0]          cpc;
   logic [8:0]          lfo;
   pllr_counter_s [6:0] cn;
   logic [8:0]          cp;
   logic [8:0]          lf;
   logic [8:0]          old_fb = 9'h001;
   logic [144:0]        cap;
   logic                sc_q = 1'b0;
   logic [31:0]         q;
   int                  ncap = 0;
   int                  err_count = 0;
   int                  check_count = 0;

   pllr_if u_pllr_if ();

   pllr_ctl u_pllr_ctl
   (
      .CLK_SYS_IN          (clk),
      .SYS_RST_IN          (rst),
      .AVS_ADDRESS_IN      (addr),
      .AVS_READ_IN         (rd),
      .AVS_WRITE_IN        (wr),
      .AVS_WRITEDATA_IN    (wdata),
      .AVS_READDATA_OUT    (rdata),
      .AVS_WAITREQUEST_OUT (waitreq),
      .IRQ_OUT             (irq),
      .link                (u_pllr_if)
   );

   pllr_device #(.UPDATE_CYC(UPD)) u_pllr_device
   (
      .CLK_SYS_IN           (clk),
      .SYS_RST_IN           (rst),
      .PLL_CLK_OUT          (pll_clk),
      .FB_FACTOR_OUT        (fb),
      .PRE_FACTOR_OUT       (pre),
      .CHARGE_PUMP_CODE_OUT (cpc),
      .LOOP_FILTER_OUT      (lfo),
      .link                 (u_pllr_if)
   );

   pllr_link_sva #(.UPDATE_CYC(UPD)) u_pllr_link_sva
   (
      .CLK_SYS_IN (clk),
      .SYS_RST_IN (rst),
      .scan_clk   (u_pllr_if.scan_clk),
      .scan_en    (u_pllr_if.scan_en),
      .scan_data  (u_pllr_if.scan_data),
      .commit     (u_pllr_if.commit),
      .pll_rst    (u_pllr_if.pll_rst),
      .done       (u_pllr_if.done)
   );

   always #2.5 clk = ~clk;

   // Record the wire bit at every enabled shift clock rise
   always @(negedge clk)
   begin
      if (u_pllr_if.scan_en === 1'b1 && u_pllr_if.scan_clk === 1'b1
          && sc_q === 1'b0)
      begin
         cap = {u_pllr_if.scan_data, cap[144:1]};
         ncap++;
      end
      sc_q = u_pllr_if.scan_clk;
   end

   function automatic logic [8:0] fac(input pllr_counter_s c);
      if (c.bypass || (c.high == 8'h00 && c.low == 8'h00))
         return 9'h001;
      return {1'b0, c.high} + {1'b0, c.low};
   endfunction

   function automatic int len(input pllr_counter_s c, input logic h);
      int n;
      n = h ? 2 * int'(c.high) - int'(c.odd) : 2 * int'(c.low) + int'(c.odd);
      return (c.bypass || n < 1) ? 1 : n;
   endfunction

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitreq !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         err_count++;
         end_of_test();
      end
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wait_done(input logic v);
      int n;
      n = 0;
      while (u_pllr_if.done !== v && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000)
      begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic measure(input int i, output int hi, output int lo);
      hi = 0;
      lo = 0;
      while (pll_clk[i] !== 1'b0 && lo < 100)
      begin
         @(negedge clk);
         lo++;
      end
      lo = 0;
      while (pll_clk[i] !== 1'b1 && lo < 100)
      begin
         @(negedge clk);
         lo++;
      end
      lo = 0;
      while (pll_clk[i] === 1'b1 && hi < 100)
      begin
         hi++;
         @(negedge clk);
      end
      while (pll_clk[i] === 1'b0 && lo < 100)
      begin
         lo++;
         @(negedge clk);
      end
   endtask

   task automatic run_cfg(input int t, input logic ra);
      logic [159:0] ch;
      logic [159:0] got;
      int           hi;
      int           lo;
      ch = {16'h0, lf, cp, cn[6], cn[5], cn[0], cn[1], cn[2], cn[3], cn[4]};
      for (int k = 0; k < 5; k++)
         bus(1'b1, 6'h10 + 6'(4 * k), ch[32 * k +: 32], q);
      bus(1'b0, 6'h10, 32'h0, q);
      chk("set0", ch[31:0], q);
      ncap = 0;
      bus(1'b1, 6'h00, {30'h0, ra, 1'b1}, q);
      wait_done(1'b1);
      got = {16'h0, cap[144:1]};
      chk("bits", 32'd145, 32'(ncap));
      for (int k = 0; k < 5; k++)
         chk("chain", ch[32 * k +: 32], got[32 * k +: 32]);
      chk("hold", 32'(old_fb), 32'(fb));
      wait_done(1'b0);
      repeat (2) @(negedge clk);
      chk("fb", 32'(fac(cn[5])), 32'(fb));
      chk("pre", 32'(fac(cn[6])), 32'(pre));
      chk("cp", 32'(cp), 32'(cpc));
      chk("lf", 32'(lf), 32'(lfo));
      old_fb = fac(cn[5]);
      hi = 0;
      do
      begin
         bus(1'b0, 6'h04, 32'h0, q);
         hi++;
      end
      while (q[0] !== 1'b0 && hi < 50);
      chk("busy", 32'h0, {31'h0, q[0]});
      bus(1'b0, 6'h00, 32'h0, q);
      chk("rst_after", {30'h0, ra, 1'b0}, q & 32'h2);
      for (int i = 0; i < 5; i++)
      begin
         measure(i, hi, lo);
         chk("high", 32'(len(cn[i], 1'b1)), 32'(hi));
         chk("low", 32'(len(cn[i], 1'b0)), 32'(lo));
      end
      $display("Test %0d done", t);
   endtask

   initial
   begin
      void'($urandom(64365));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("fb_rst", 32'h1, 32'(fb));
      chk("cp_rst", 32'h0, 32'(cpc));
      chk("irq_rst", 32'h0, {31'h0, irq});
      bus(1'b1, 6'h3c, 32'hffff_ffff, q);
      bus(1'b0, 6'h3c, 32'h0, q);
      chk("unmapped", 32'h0, q);
      $display("Test 0 done");
      for (int t = 1; t <= 3; t++)
      begin
         for (int j = 0; j < 7; j++)
            cn[j] = {2'($urandom), 8'($urandom_range(6, 1)),
                     8'($urandom_range(6, 1))};
         cp = 9'($urandom);
         lf = 9'($urandom);
         if (t == 1)
         begin
            // Bypass with junk fields, odd divide by three, zero feedback
            cn[0] = {2'h1, 8'hff, 8'h00};
            cn[1] = {2'h2, 8'h02, 8'h01};
            cn[2] = {2'h0, 8'h05, 8'h03};
            cn[5] = 18'h0;
         end
         run_cfg(t, t == 2);
         if (t == 1)
         begin
            chk("irq_mask", 32'h0, {31'h0, irq});
            bus(1'b0, 6'h08, 32'h0, q);
            chk("irq_st", 32'h1, q & 32'h1);
            bus(1'b1, 6'h0c, 32'h1, q);
            @(negedge clk);
            chk("irq_on", 32'h1, {31'h0, irq});
            bus(1'b1, 6'h08, 32'h1, q);
            @(negedge clk);
            chk("irq_clr", 32'h0, {31'h0, irq});
         end
      end
      end_of_test();
   end

   initial
   begin
      #200000;
      err_count++;
      end_of_test();
   end
endmodule

`default_nettype wire
